// >>> shared/cycle_steal_pkg.sv
// constants, register map and carriers for the memory cycle-steal and timer block
// Operation
// - channel request raises master level at A5 D2
// - channel level starts memory timing, blocks address
// - cpu cycles keep master, lose early/late levels
// - channel write loads storage bus into data register
// - channel read gates data register onto bus
// - u request starts operand sequence, suppresses extras
// - timer word at 00005 updated in three cycles
// - first timer cycle forces address bits, reads
// - timer early starts late, loads staging register
// - delayed cycle adds one at bit 35
// - delayed cycle swaps accumulator and staging register
// - end of delayed cycle launches second timer cycle
// - second cycle writes staging word back, ends
// - timer request at A4 D1, only without b/u
// - mains buffer set A2 D1, reset A4 D1
// - buffer sets early request, interlock, request latch
// - interlock clears and blocks early request
// - complete level clears request, ends operation
// - u early clears complete latch, update repeats
package cycle_steal_pkg;
   localparam int unsigned WORD_W = 36;
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned PHASES = 6;
   // phase pulse indices within a machine cycle
   localparam logic [2:0] PH_A0 = 3'h0;
   localparam logic [2:0] PH_A1 = 3'h1;
   localparam logic [2:0] PH_A2 = 3'h2;
   localparam logic [2:0] PH_A3 = 3'h3;
   localparam logic [2:0] PH_A4 = 3'h4;
   localparam logic [2:0] PH_A5 = 3'h5;
   // timer word location: bits 33 and 35 in 36-bit numbering
   localparam logic [ADDR_W-1:0] TIMER_ADDR = 15'h0005;
   localparam logic [WORD_W-1:0] TIMER_INC  = 36'h000000001;
   // apb map
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] SR_LO_OFS  = 8'h08;
   localparam logic [7:0] AC_LO_OFS  = 8'h0c;
   localparam logic [7:0] HI_OFS     = 8'h10;
   localparam logic [7:0] COUNT_OFS  = 8'h14;
   localparam int unsigned CTRL_TIMER_EN = 0;
   localparam logic [31:0] CTRL_RESET = 32'h00000001;

   typedef enum logic [2:0] {
      T_IDLE, T_FIRST, T_DELAYED, T_SECOND
   } timer_state_e;

   typedef struct packed {
      logic             b_req;
      logic             b_write;
      logic             u_req;
   } chan_req_s;

   typedef struct packed {
      logic              mem_start;
      logic              mem_store;
      logic              ar_to_mar_block;
      logic [ADDR_W-1:0] mar_force;
      logic              mar_force_en;
      logic              mdr_to_bus;
      logic              bus_to_mdr;
   } mem_ctl_s;
endpackage

// >>> src/cycle_steal.sv
// channel cycle stealing, u-cycle hand-off and interval timer update control
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module cycle_steal #(
   parameter int unsigned WORD_W = cycle_steal_pkg::WORD_W,
   parameter int unsigned ADDR_W = cycle_steal_pkg::ADDR_W
) (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // channels
   input  wire cycle_steal_pkg::chan_req_s  chan,
   input  wire logic [WORD_W-1:0]           storage_bus_in,
   output logic [WORD_W-1:0]                storage_bus_out,
   output logic                             storage_bus_oe_n,
   // mains clamp outputs, asynchronous
   input  wire logic                        clamp_short,
   input  wire logic                        clamp_long,
   // cpu cycle requests
   input  wire logic                        cpu_master_i,
   input  wire logic                        cpu_master_e,
   input  wire logic [WORD_W-1:0]           mem_read_data,
   // memory and cycle control
   output cycle_steal_pkg::mem_ctl_s        mem_ctl,
   output logic [WORD_W-1:0]                memory_data_reg,
   output logic                             master_b,
   output logic                             cpu_early_en,
   output logic                             u_operand_start,
   output logic                             u_suppress,
   output logic                             timer_busy
);
   initial begin
      if (WORD_W != 36 || ADDR_W < 15) $error("cycle_steal: unsupported widths");
   end

   logic [2:0] phase;
   logic       d2;
   logic       cycle_end;
   logic       ph_a0_d1, ph_a1_d1, ph_a2_d1, ph_a3_d1, ph_a4_d1, ph_a5_d1, ph_a5_d2;
   logic [1:0] clamp_q;
   logic       clamp_short_s, clamp_long_s;

   ////////////////////////////////////////////////////////////////////////////////
   phase_gen #(
      .NPH       (cycle_steal_pkg::PHASES)
   ) u_phase (
      .clk       (clk),
      .rst_n     (rst_n),
      .phase     (phase),
      .d2        (d2),
      .cycle_end (cycle_end)
   );

   sync2 #(
      .W     (2)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({clamp_long, clamp_short}),
      .q     (clamp_q)
   );
   assign clamp_short_s = clamp_q[0];
   assign clamp_long_s  = clamp_q[1];

   assign ph_a0_d1 = !d2 && phase == cycle_steal_pkg::PH_A0;
   assign ph_a1_d1 = !d2 && phase == cycle_steal_pkg::PH_A1;
   assign ph_a2_d1 = !d2 && phase == cycle_steal_pkg::PH_A2;
   assign ph_a3_d1 = !d2 && phase == cycle_steal_pkg::PH_A3;
   assign ph_a4_d1 = !d2 && phase == cycle_steal_pkg::PH_A4;
   assign ph_a5_d1 = !d2 && phase == cycle_steal_pkg::PH_A5;
   assign ph_a5_d2 =  d2 && phase == cycle_steal_pkg::PH_A5;

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_r;
   logic [15:0] update_count_r;
   logic        timer_en;
   assign timer_en = ctrl_r[cycle_steal_pkg::CTRL_TIMER_EN];

   ////////////////////////////////////////////////////////////////////////////////
   // channel (b) cycles
   // length is the channel's business; we only follow its request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         master_b <= 1'b0;
      end else if (ph_a5_d2 && chan.b_req) begin
         // raise and renew master at A5 D2
         master_b <= 1'b1;
      end else if (ph_a5_d1 && !chan.b_req) begin
         // drop at A5 D1 without request
         master_b <= 1'b0;
      end
   end

   logic b_req_or_master;
   assign b_req_or_master = chan.b_req || master_b;

   assign cpu_early_en = !master_b && (cpu_master_i || cpu_master_e);

   // u request runs operand hardware trimmed
   assign u_operand_start = chan.u_req;
   assign u_suppress      = chan.u_req;

   ////////////////////////////////////////////////////////////////////////////////
   // mains request chain
   logic mains_buf_r;
   logic early_req_r;
   logic interlock_r;
   logic timer_req_r;
   logic complete_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mains_buf_r <= 1'b0;
      end else if (ph_a2_d1 && clamp_short_s) begin
         // set by short clamp at A2 D1
         mains_buf_r <= 1'b1;
      end else if (ph_a4_d1 && !clamp_long_s) begin
         // reset only with long clamp down
         mains_buf_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         early_req_r <= 1'b0;
      end else if (interlock_r && ph_a4_d1) begin
         early_req_r <= 1'b0;
      end else if (ph_a0_d1 && mains_buf_r && timer_en && !interlock_r) begin
         early_req_r <= 1'b1;
      end
   end

   logic timer_done;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         interlock_r <= 1'b0;
      end else if (ph_a2_d1 && early_req_r) begin
         interlock_r <= 1'b1;
      end else if (ph_a0_d1 && !timer_req_r && !mains_buf_r) begin
         interlock_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer_req_r <= 1'b0;
      end else if (ph_a4_d1 && early_req_r) begin
         // request at first A4 D1 after peak
         timer_req_r <= 1'b1;
      end else if (timer_done) begin
         timer_req_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timer cycle sequence
   cycle_steal_pkg::timer_state_e tstate_r;
   logic [WORD_W-1:0] staging_register;
   logic [WORD_W-1:0] accumulator_r;
   logic [WORD_W-1:0] adder;
   logic              go_timer_cycle;

   // only with no b or u request
   assign go_timer_cycle = timer_req_r && !chan.b_req && !chan.u_req && !master_b;
   // complete level seen at A4 D1 of last cycle
   assign timer_done = ph_a4_d1 && complete_r && tstate_r == cycle_steal_pkg::T_SECOND;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tstate_r <= cycle_steal_pkg::T_IDLE;
      end else if (chan.u_req && tstate_r != cycle_steal_pkg::T_IDLE) begin
         // u cycle pre-empts, sequence restarts later
         tstate_r <= cycle_steal_pkg::T_IDLE;
      end else if (cycle_end) begin
         case (tstate_r)
            cycle_steal_pkg::T_IDLE:    if (go_timer_cycle) tstate_r <= cycle_steal_pkg::T_FIRST;
            cycle_steal_pkg::T_FIRST:   tstate_r <= cycle_steal_pkg::T_DELAYED;
            // end of delayed cycle launches the second
            cycle_steal_pkg::T_DELAYED: tstate_r <= cycle_steal_pkg::T_SECOND;
            cycle_steal_pkg::T_SECOND:  tstate_r <= cycle_steal_pkg::T_IDLE;
            default:                    tstate_r <= cycle_steal_pkg::T_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         complete_r <= 1'b0;
      end else if (ph_a0_d1 && chan.u_req) begin
         complete_r <= 1'b0;
      end else if (cycle_end && tstate_r == cycle_steal_pkg::T_DELAYED) begin
         // complete level at end of delayed cycle
         complete_r <= 1'b1;
      end else if (timer_done) begin
         complete_r <= 1'b0;
      end
   end

   // add one at low-order bit 35
   assign adder = staging_register + cycle_steal_pkg::TIMER_INC;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         staging_register <= '0;
         accumulator_r    <= '0;
      end else if (chan.u_req && tstate_r != cycle_steal_pkg::T_IDLE) begin
         // u cycle discards partial timer word
         staging_register <= '0;
      end else if (tstate_r == cycle_steal_pkg::T_FIRST && ph_a4_d1) begin
         // memory read word into staging register
         staging_register <= mem_read_data;
      end else if (tstate_r == cycle_steal_pkg::T_DELAYED && (ph_a1_d1 || ph_a3_d1)) begin
         // swap at A1 and again at A3
         accumulator_r    <= ph_a1_d1 ? adder : staging_register;
         staging_register <= accumulator_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // memory control
   logic t_mem;
   assign t_mem      = tstate_r == cycle_steal_pkg::T_FIRST || tstate_r == cycle_steal_pkg::T_SECOND;
   assign timer_busy = tstate_r != cycle_steal_pkg::T_IDLE;

   always_comb begin
      mem_ctl = '0;
      // memory timing start, address transfer blocked
      mem_ctl.mem_start       = b_req_or_master || t_mem;
      // timer blocks other cycles from the address path
      mem_ctl.ar_to_mar_block = b_req_or_master || timer_busy;
      mem_ctl.mar_force_en    = t_mem;
      mem_ctl.mar_force       = ADDR_W'(cycle_steal_pkg::TIMER_ADDR);
      // channel write is a store cycle
      mem_ctl.mem_store       = (master_b && chan.b_write) ||
                                tstate_r == cycle_steal_pkg::T_SECOND;
      mem_ctl.bus_to_mdr      = mem_ctl.mem_store;
      // read gates data register to bus
      mem_ctl.mdr_to_bus      = master_b && !chan.b_write;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         memory_data_reg <= '0;
      end else if (master_b && chan.b_write) begin
         memory_data_reg <= storage_bus_in;
      end else if (tstate_r == cycle_steal_pkg::T_SECOND && complete_r) begin
         memory_data_reg <= staging_register;
      end else if (master_b || tstate_r == cycle_steal_pkg::T_FIRST) begin
         memory_data_reg <= mem_read_data;
      end
   end

   // bus driven toward channel on reads
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         storage_bus_out  <= '0;
         storage_bus_oe_n <= 1'b1;
      end else begin
         storage_bus_out  <= memory_data_reg;
         storage_bus_oe_n <= !(master_b && !chan.b_write);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) update_count_r <= '0;
      else if (timer_done) update_count_r <= update_count_r + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   logic apb_acc;
   logic map_hit;
   assign apb_acc = psel && penable;
   assign pready  = 1'b1;
   assign map_hit = paddr == cycle_steal_pkg::CTRL_OFS   || paddr == cycle_steal_pkg::STATUS_OFS ||
                    paddr == cycle_steal_pkg::SR_LO_OFS  || paddr == cycle_steal_pkg::AC_LO_OFS  ||
                    paddr == cycle_steal_pkg::HI_OFS     || paddr == cycle_steal_pkg::COUNT_OFS;
   assign pslverr = apb_acc && !map_hit;

   always_ff @(posedge clk) begin
      if (!rst_n) ctrl_r <= cycle_steal_pkg::CTRL_RESET;
      else if (apb_acc && pwrite && paddr == cycle_steal_pkg::CTRL_OFS) ctrl_r <= {31'h0, pwdata[0]};
   end

   always_comb begin
      prdata = 32'h00000000;
      case (paddr)
         cycle_steal_pkg::CTRL_OFS:   prdata = ctrl_r;
         cycle_steal_pkg::STATUS_OFS: prdata = {22'h0, master_b, complete_r, timer_req_r,
                                                interlock_r, early_req_r, mains_buf_r,
                                                1'b0, tstate_r};
         cycle_steal_pkg::SR_LO_OFS:  prdata = staging_register[31:0];
         cycle_steal_pkg::AC_LO_OFS:  prdata = accumulator_r[31:0];
         cycle_steal_pkg::HI_OFS:     prdata = {24'h0, accumulator_r[35:32], staging_register[35:32]};
         cycle_steal_pkg::COUNT_OFS:  prdata = {16'h0, update_count_r};
         default:                     prdata = 32'h00000000;
      endcase
   end
endmodule // cycle_steal

// >>> src/phase_gen.sv
// machine-cycle phase pulse generator, A0..A5 with D1/D2 halves
`timescale 1ns/1ps
module phase_gen #(
   parameter int unsigned NPH = cycle_steal_pkg::PHASES
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   output logic [2:0]      phase,
   output logic            d2,
   output logic            cycle_end
);
   initial begin
      if (NPH < 5 || NPH > 8) $error("phase_gen: NPH out of range");
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase <= cycle_steal_pkg::PH_A0;
         d2    <= 1'b0;
      end else begin
         d2 <= ~d2;
         if (d2) begin
            if (phase == 3'(NPH - 1)) phase <= cycle_steal_pkg::PH_A0;
            else phase <= phase + 3'h1;
         end
      end
   end

   // last half-phase of the machine cycle
   assign cycle_end = d2 && (phase == 3'(NPH - 1));
endmodule // phase_gen

// >>> src/sync2.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_r;

   initial begin
      if (W < 1) $error("sync2: W must be positive");
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sync2

// >>> test/chan_model.sv
// far-side channel model: cycle requests, storage bus data and one core word
`timescale 1ns/1ps
module chan_model (
   input  wire logic                                clk,
   input  wire logic                                want_b,
   input  wire logic                                want_write,
   input  wire logic                                want_u,
   input  wire logic [cycle_steal_pkg::WORD_W-1:0]  wdata,
   input  wire cycle_steal_pkg::mem_ctl_s           mem_ctl,
   input  wire logic [cycle_steal_pkg::WORD_W-1:0]  memory_data_reg,
   output cycle_steal_pkg::chan_req_s               chan,
   output logic [cycle_steal_pkg::WORD_W-1:0]       storage_bus_in,
   output logic [cycle_steal_pkg::WORD_W-1:0]       core_r
);
   initial begin
      chan = '0;
      storage_bus_in = '0;
      core_r = '0;
   end
   always @(posedge clk) begin
      chan.b_req <= want_b;
      chan.b_write <= want_b & want_write;
      chan.u_req <= want_u;
   end
   // released bus shows the inverse, never a stale copy
   always @(posedge clk) begin
      storage_bus_in <= (want_b & want_write) ? wdata : ~wdata;
   end
   // last store of a cycle is the word that lands in core
   always @(posedge clk) begin
      if (mem_ctl.mem_store) begin
         core_r <= memory_data_reg;
      end
   end
endmodule // chan_model

// >>> test/cycle_steal_checker.sv
// assertion checker for the cycle-steal and timer block
`timescale 1ns/1ps
module cycle_steal_checker #(
   parameter int unsigned WORD_W = cycle_steal_pkg::WORD_W,
   parameter int unsigned ADDR_W = cycle_steal_pkg::ADDR_W
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic [7:0]                 paddr,
   input  wire logic                       pready,
   input  wire logic                       pslverr,
   input  wire cycle_steal_pkg::chan_req_s chan,
   input  wire cycle_steal_pkg::mem_ctl_s  mem_ctl,
   input  wire logic                       master_b,
   input  wire logic                       cpu_early_en,
   input  wire logic                       u_operand_start,
   input  wire logic                       u_suppress,
   input  wire logic                       timer_busy
);
   logic [5:0] busy_cnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // a stuck sequencer shows as an overlong busy run
   always_ff @(posedge clk) begin
      if (!rst_n || !timer_busy) begin
         busy_cnt_r <= 6'h00;
      end else if (busy_cnt_r != 6'h3f) begin
         busy_cnt_r <= busy_cnt_r + 6'h01;
      end
   end
   // master level cannot drop before the next A4 D1
   sequence b_hold_s;
      master_b [*8];
   endsequence
   ////////////////////////////////////////////////////////////
   master_set_a: assert property ($rose(master_b) |-> $past(chan.b_req))
      else $error("channel master rose without request");
   master_keep_a: assert property (master_b && chan.b_req |=> master_b)
      else $error("channel master dropped under request");
   master_min_a: assert property ($rose(master_b) |=> b_hold_s)
      else $error("channel master dropped before cycle end");
   addr_block_a: assert property (master_b |-> mem_ctl.ar_to_mar_block && mem_ctl.mem_start)
      else $error("address transfer not blocked in channel cycle");
   cpu_hold_a: assert property (master_b |-> !cpu_early_en)
      else $error("cpu early level during channel cycle");
   chan_store_a: assert property (master_b && chan.b_write |-> mem_ctl.mem_store && mem_ctl.bus_to_mdr)
      else $error("channel write without store cycle");
   chan_fetch_a: assert property (master_b && !chan.b_write |-> mem_ctl.mdr_to_bus)
      else $error("channel read without data gating");
   u_start_a: assert property (chan.u_req && !master_b |-> u_operand_start && u_suppress)
      else $error("u request did not start operand sequence");
   force_addr_a: assert property (mem_ctl.mar_force_en |-> mem_ctl.mar_force == cycle_steal_pkg::TIMER_ADDR && timer_busy)
      else $error("forced address wrong or outside timer update");
   timer_len_a: assert property (busy_cnt_r <= 6'h24)
      else $error("timer update longer than three machine cycles");
   timer_gate_a: assert property ($rose(timer_busy) |-> !$past(chan.b_req) && !$past(chan.u_req))
      else $error("timer update started under b or u request");
   u_preempt_a: assert property (chan.u_req && timer_busy |-> ##[0:12] !timer_busy)
      else $error("u request did not pre-empt timer update");
   apb_err_a: assert property (psel && penable && paddr > cycle_steal_pkg::COUNT_OFS |-> pslverr && pready)
      else $error("unmapped access not refused");
endmodule // cycle_steal_checker

bind cycle_steal cycle_steal_checker #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) cycle_steal_checker_i (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .chan(chan), .mem_ctl(mem_ctl), .master_b(master_b),
   .cpu_early_en(cpu_early_en), .u_operand_start(u_operand_start), .u_suppress(u_suppress),
   .timer_busy(timer_busy));

// >>> test/cycle_steal_tb_top.sv
// self-checking bench: apb access, channel cycles and timer updates
`timescale 1ns/1ps
module cycle_steal_tb_top;
   logic                       clk          = 1'b0;
   logic                       rst_n        = 1'b0;
   logic                       psel         = 1'b0;
   logic                       penable      = 1'b0;
   logic                       pwrite       = 1'b0;
   logic [7:0]                 paddr        = 8'h00;
   logic [31:0]                pwdata       = 32'h0;
   logic                       want_b       = 1'b0;
   logic                       want_write   = 1'b0;
   logic                       want_u       = 1'b0;
   logic [35:0]                wdata        = 36'h0;
   logic                       clamp_short  = 1'b0;
   logic                       clamp_long   = 1'b0;
   logic                       cpu_master_e = 1'b0;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   cycle_steal_pkg::chan_req_s chan;
   cycle_steal_pkg::mem_ctl_s  mem_ctl;
   logic [35:0]                storage_bus_in;
   logic [35:0]                storage_bus_out;
   logic [35:0]                memory_data_reg;
   logic [35:0]                core_r;
   logic                       storage_bus_oe_n;
   logic                       master_b;
   logic                       cpu_early_en;
   logic                       u_operand_start;
   logic                       u_suppress;
   logic                       timer_busy;
   logic [35:0]                rd;
   int                         n_errors     = 0;
   int                         n_checks     = 0;
   int                         cycles       = 0;
   int                         i;

   always #12.5 clk = ~clk;

   cycle_steal cycle_steal_i (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan(chan), .storage_bus_in(storage_bus_in), .storage_bus_out(storage_bus_out),
      .storage_bus_oe_n(storage_bus_oe_n), .clamp_short(clamp_short),
      .clamp_long(clamp_long), .cpu_master_i(1'b0), .cpu_master_e(cpu_master_e),
      .mem_read_data(core_r), .mem_ctl(mem_ctl), .memory_data_reg(memory_data_reg),
      .master_b(master_b), .cpu_early_en(cpu_early_en), .u_operand_start(u_operand_start),
      .u_suppress(u_suppress), .timer_busy(timer_busy));

   chan_model chan_model_i (
      .clk(clk), .want_b(want_b), .want_write(want_write), .want_u(want_u), .wdata(wdata),
      .mem_ctl(mem_ctl), .memory_data_reg(memory_data_reg), .chan(chan),
      .storage_bus_in(storage_bus_in), .core_r(core_r));
   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; rd gets {pslverr, prdata}
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = {3'h0, pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // clamp levels are asynchronous to the phases
   task automatic pulse_mains();
      clamp_short <= 1'b1;
      clamp_long <= 1'b1;
      repeat (30) @(posedge clk);
      clamp_short <= 1'b0;
      repeat (30) @(posedge clk);
      clamp_long <= 1'b0;
   endtask

   task automatic wait_core(input logic [35:0] exp);
      for (i = 0; i < 400 && core_r !== exp; i++) @(posedge clk);
      check(core_r, exp);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, cycle_steal_pkg::CTRL_OFS, 32'h0);
      check(rd, {4'h0, cycle_steal_pkg::CTRL_RESET});
      apb(1'b0, cycle_steal_pkg::COUNT_OFS, 32'h0);
      check(rd, 36'h0);
      apb(1'b1, 8'h18, 32'h5);
      check(rd, 36'h100000000);
      apb(1'b1, cycle_steal_pkg::CTRL_OFS, 32'h0);
      apb(1'b0, cycle_steal_pkg::CTRL_OFS, 32'h0);
      check(rd, 36'h0);
      apb(1'b1, cycle_steal_pkg::CTRL_OFS, 32'h1);
      // channel write of three machine cycles, cpu held off
      wdata <= 36'h9a5c3e17b;
      want_write <= 1'b1;
      want_b <= 1'b1;
      cpu_master_e <= 1'b1;
      for (i = 0; i < 14 && !master_b; i++) @(posedge clk);
      check({35'h0, master_b}, 36'h1);
      check({35'h0, cpu_early_en}, 36'h0);
      repeat (24) @(posedge clk);
      want_b <= 1'b0;
      for (i = 0; i < 14 && master_b; i++) @(posedge clk);
      check({35'h0, master_b}, 36'h0);
      check(core_r, 36'h9a5c3e17b);
      repeat (2) @(posedge clk);
      check({35'h0, cpu_early_en}, 36'h1);
      // channel read gets the core word
      want_write <= 1'b0;
      want_b <= 1'b1;
      for (i = 0; i < 14 && !master_b; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      check({35'h0, storage_bus_oe_n}, 36'h0);
      check(storage_bus_out, 36'h9a5c3e17b);
      // timer held off by the channel, then runs
      pulse_mains();
      check({35'h0, timer_busy}, 36'h0);
      want_b <= 1'b0;
      wait_core(36'h9a5c3e17c);
      repeat (40) @(posedge clk);
      apb(1'b0, cycle_steal_pkg::COUNT_OFS, 32'h0);
      check(rd, 36'h1);
      apb(1'b0, cycle_steal_pkg::STATUS_OFS, 32'h0);
      check(rd, 36'h0);
      apb(1'b0, cycle_steal_pkg::SR_LO_OFS, 32'h0);
      check(rd, 36'h0a5c3e17c);
      apb(1'b0, cycle_steal_pkg::HI_OFS, 32'h0);
      check(rd, 36'h9);
      apb(1'b0, cycle_steal_pkg::AC_LO_OFS, 32'h0);
      check(rd, 36'h0);
      // u request breaks into the delayed cycle
      fork
         pulse_mains();
         begin
            for (i = 0; i < 200 && !timer_busy; i++) @(posedge clk);
            repeat (15) @(posedge clk);
            want_u <= 1'b1;
            repeat (20) @(posedge clk);
            check({34'h0, u_operand_start, u_suppress}, 36'h3);
            check({35'h0, timer_busy}, 36'h0);
            apb(1'b0, cycle_steal_pkg::SR_LO_OFS, 32'h0);
            check(rd, 36'h0);
            check(core_r, 36'h9a5c3e17c);
            want_u <= 1'b0;
         end
      join
      wait_core(36'h9a5c3e17d);
      repeat (40) @(posedge clk);
      apb(1'b0, cycle_steal_pkg::COUNT_OFS, 32'h0);
      check(rd, 36'h2);
      stop_test();
   end
endmodule // cycle_steal_tb_top
